/* File: logic/gpio_audio_pkg.sv */
package gpio_audio_pkg;

    // register offsets on the configuration port
    localparam logic [7:0] OFF_GPIO0 = 8'h0D;
    localparam logic [7:0] OFF_GPIO12 = 8'h0E;
    localparam logic [7:0] OFF_GPIO3_OUT4 = 8'h0F;
    localparam logic [7:0] OFF_OUT56 = 8'h10;
    localparam logic [7:0] OFF_OUT78 = 8'h11;
    localparam logic [7:0] OFF_GENERAL = 8'h12;
    localparam logic [7:0] OFF_STATUS = 8'h13;

    // every configuration register clears to this value
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;

    // fields inside one configuration nibble
    localparam int NIB_EN = 0;
    localparam int NIB_FWD = 1;
    localparam int NIB_BACK = 2;
    localparam int NIB_LEVEL = 3;

    // fields of the general configuration register
    localparam int GEN_CHB = 0;
    localparam int GEN_ACTIVE = 1;
    localparam int GEN_MODE18 = 2;

    // fields of the status register
    localparam int ST_MODE18 = 0;
    localparam int ST_CHB = 1;
    localparam int ST_RATE_ERR = 2;
    localparam int ST_BIST_OK = 3;

    // audio bit clock timing: periods in ns, minimum bit length in pixel clocks
    localparam int PCLK_NS = 100;
    localparam int BIT_PERIOD_NS = 400;
    localparam int MIN_BIT_CYCLES = (BIT_PERIOD_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int AUDIO_MAX_BITS = 32;
    localparam logic [5:0] LEN_ZERO = 6'h00;
    localparam logic [2:0] GAP_ZERO = 3'h0;
    // gap count after reset and when the bit clock is idle; saturated so the
    // first rise after reset is never taken for a rate fault
    localparam logic [2:0] GAP_FULL = 3'h7;

    // stored configuration, one byte each
    typedef struct packed {
        logic [7:0] general;
        logic [7:0] out78;
        logic [7:0] out56;
        logic [7:0] gpio3_out4;
        logic [7:0] gpio12;
        logic [7:0] gpio0;
    } cfg_t;

    // one register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // one captured audio word for both data lines
    typedef struct packed {
        logic wc;
        logic [5:0] len;
        logic has_b;
        logic [31:0] sample_a;
        logic [31:0] sample_b;
    } audio_word_t;

    // payload handed to the link each pixel clock
    typedef struct packed {
        logic [23:0] rgb;
        logic de;
        logic mode18;
        logic [3:0] gpio;
        logic audio_valid;
        logic audio_in_active;
        audio_word_t audio;
    } fwd_frame_t;

    // pick one configuration nibble out of a byte
    function automatic logic [3:0] nibble(input logic [7:0] b, input logic hi);
        nibble = hi ? b[7:4] : b[3:0];
    endfunction : nibble

endpackage : gpio_audio_pkg

/* File: logic/cfg_regs.sv */
`timescale 1ns/10ps
module cfg_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // access port
    input gpio_audio_pkg::reg_req_t req,
    input wire logic [7:0] status,
    output gpio_audio_pkg::cfg_t cfg,
    output logic [7:0] rdata,
    output logic rvalid
);
    import gpio_audio_pkg::*;

    cfg_t next_cfg; // configuration after this access
    logic [7:0] next_rdata; // read answer
    logic next_rvalid;

    // decode the write and the read
    always_comb begin
        next_cfg = cfg;
        next_rdata = READ_NONE;
        next_rvalid = req.rd;
        if (req.wr) begin
            case (req.addr)
                OFF_GPIO0: next_cfg.gpio0 = req.wdata;
                OFF_GPIO12: next_cfg.gpio12 = req.wdata;
                OFF_GPIO3_OUT4: next_cfg.gpio3_out4 = req.wdata;
                OFF_OUT56: next_cfg.out56 = req.wdata;
                OFF_OUT78: next_cfg.out78 = req.wdata;
                OFF_GENERAL: next_cfg.general = req.wdata;
                default: next_cfg = cfg; // unmapped writes are dropped
            endcase
        end
        case (req.addr)
            OFF_GPIO0: next_rdata = cfg.gpio0;
            OFF_GPIO12: next_rdata = cfg.gpio12;
            OFF_GPIO3_OUT4: next_rdata = cfg.gpio3_out4;
            OFF_OUT56: next_rdata = cfg.out56;
            OFF_OUT78: next_rdata = cfg.out78;
            OFF_GENERAL: next_rdata = cfg.general;
            OFF_STATUS: next_rdata = status;
            default: next_rdata = READ_NONE;
        endcase
    end

    // everything clears so no pin wakes up active
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= {6{REG_RESET}};
            rdata <= READ_NONE;
            rvalid <= 1'b0;
        end else begin
            cfg <= next_cfg;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

endmodule : cfg_regs

/* File: logic/audio_capture.sv */
`timescale 1ns/10ps
module audio_capture (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // audio pins, sampled on the pixel clock
    input wire logic bclk,
    input wire logic wclk,
    input wire logic data_a,
    input wire logic data_b,
    input wire logic chb_en,
    // captured words
    output gpio_audio_pkg::audio_word_t word,
    output logic word_valid,
    output logic rate_err
);
    import gpio_audio_pkg::*;

    logic bclk_q; // previous bit clock level
    logic wc_q; // word clock at the last bit
    logic [5:0] len; // bits in the current word
    logic [31:0] sh_a;
    logic [31:0] sh_b;
    logic [2:0] gap; // pixel clocks since the last bit
    logic next_wc_q;
    logic [5:0] next_len;
    logic [31:0] next_sh_a;
    logic [31:0] next_sh_b;
    logic [2:0] next_gap;
    audio_word_t next_word;
    logic next_word_valid;
    logic next_rate_err;
    logic rise;

    // shift on each bit clock rise; a word clock change closes the word
    always_comb begin
        rise = bclk & ~bclk_q;
        next_wc_q = wc_q;
        next_len = len;
        next_sh_a = sh_a;
        next_sh_b = sh_b;
        next_gap = (gap == GAP_FULL) ? gap : gap + 3'h1;
        next_word = word;
        next_word_valid = 1'b0;
        next_rate_err = 1'b0;
        if (rise) begin
            next_gap = GAP_ZERO;
            // the source must hold one bit for four pixel clocks
            next_rate_err = (gap < 3'(MIN_BIT_CYCLES - 1));
            next_wc_q = wclk;
            if (wclk != wc_q && len != LEN_ZERO) begin
                next_word.wc = wc_q;
                next_word.len = len;
                next_word.has_b = chb_en;
                next_word.sample_a = sh_a;
                next_word.sample_b = chb_en ? sh_b : 32'h0;
                next_word_valid = 1'b1;
                next_len = 6'h1;
                next_sh_a = {31'h0, data_a};
                next_sh_b = {31'h0, data_b};
            end else begin
                // words longer than 32 bits keep the last 32
                next_len = (len == 6'(AUDIO_MAX_BITS)) ? len : len + 6'h1;
                next_sh_a = {sh_a[30:0], data_a};
                next_sh_b = {sh_b[30:0], data_b};
            end
        end
    end

    // capture state
    always_ff @(posedge clk) begin
        if (rst) begin
            bclk_q <= 1'b0;
            wc_q <= 1'b0;
            len <= LEN_ZERO;
            sh_a <= 32'h0;
            sh_b <= 32'h0;
            gap <= GAP_FULL; // no earlier rise to measure against
            word <= '0;
            word_valid <= 1'b0;
            rate_err <= 1'b0;
        end else begin
            bclk_q <= bclk;
            wc_q <= next_wc_q;
            len <= next_len;
            sh_a <= next_sh_a;
            sh_b <= next_sh_b;
            gap <= next_gap;
            word <= next_word;
            word_valid <= next_word_valid;
            rate_err <= next_rate_err;
        end
    end

endmodule : audio_capture

/* File: logic/gpio_audio_core.sv */
`timescale 1ns/10ps
// Contract
// - channel B off gives 24-bit unless 0x12 bit 2 is set, on gives 18-bit
// - 18-bit frees four colour inputs as pins
// - pins idle until enabled by register
// - 0x12=0x04 enters 18-bit, remote follows
// - forward pins 2,1,0 by 0x30,0x03,0x93
// - back pins 2,1,0 by 0x50,0x05,0x95
// - output pins follow local register bits only
// - 0x11 drives output pins 8 and 7
// - 0x10 drives pins 6,5; 0x0F pin 4
// - 24-bit mode takes three audio inputs
// - audio packed into blanking or active video
// - channel B by strap or general bit 0
// - 32 to 192 kHz, 16/24/32-bit words
// - no self-test in backward-compatible mode
module gpio_audio_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration port
    input gpio_audio_pkg::reg_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // straps
    input wire logic strap_chb,
    input wire logic strap_backcompat,
    // video pins; the low red and green bits double as general pins
    input wire logic [23:0] rgb_in,
    input wire logic de_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    // audio pins
    input wire logic i2s_bclk,
    input wire logic i2s_wclk,
    input wire logic i2s_data,
    input wire logic second_audio_data,
    // register driven output pins 8..4
    output logic [8:4] register_driven_outputs,
    // link side
    input wire logic [3:0] back_gpio,
    output gpio_audio_pkg::fwd_frame_t fwd,
    output logic remote_mode18,
    output logic bist_allowed
);
    import gpio_audio_pkg::*;

    cfg_t cfg; // stored configuration
    audio_word_t cap_word; // word from the capture unit
    logic cap_valid;
    logic cap_rate_err;
    logic rate_err; // sticky bit rate fault
    logic next_rate_err;
    logic [7:0] status;
    logic mode18; // 18-bit colour mode in force
    logic chb; // second audio line accepted
    logic [3:0] pin_cfg [4]; // per general pin nibble
    logic [3:0] fwd_en;
    logic [3:0] back_en;
    audio_word_t pend; // word waiting for its slot
    logic pend_valid;
    audio_word_t next_pend;
    logic next_pend_valid;
    fwd_frame_t next_fwd;
    logic [3:0] next_gpio_out;
    logic [3:0] next_gpio_oe;
    logic [8:4] next_outs;
    logic slot; // this cycle may carry audio

    // configuration storage with registered read answer
    cfg_regs u_regs (
        .clk(clk),
        .rst(rst),
        .req(req),
        .status(status),
        .cfg(cfg),
        .rdata(rdata),
        .rvalid(rvalid)
    );

    // audio capture on the pixel clock
    audio_capture u_audio (
        .clk(clk),
        .rst(rst),
        .bclk(i2s_bclk),
        .wclk(i2s_wclk),
        .data_a(i2s_data),
        .data_b(second_audio_data),
        .chb_en(chb),
        .word(cap_word),
        .word_valid(cap_valid),
        .rate_err(cap_rate_err)
    );

    // mode decode: strap or register selects channel B and 18-bit
    always_comb begin
        chb = strap_chb | cfg.general[GEN_CHB];
        // writing 0x04 also enters 18-bit mode without channel B
        mode18 = chb | cfg.general[GEN_MODE18];
        pin_cfg[0] = nibble(cfg.gpio0, 1'b0);
        pin_cfg[1] = nibble(cfg.gpio12, 1'b0);
        pin_cfg[2] = nibble(cfg.gpio12, 1'b1);
        pin_cfg[3] = nibble(cfg.gpio3_out4, 1'b0);
        for (int i = 0; i < 4; i++) begin
            // 0x3 in a nibble is forward input, 0x5 is back output
            fwd_en[i] = mode18 & pin_cfg[i][NIB_EN] & pin_cfg[i][NIB_FWD];
            back_en[i] = mode18 & pin_cfg[i][NIB_EN] & pin_cfg[i][NIB_BACK];
        end
        status = 8'h00;
        status[ST_MODE18] = mode18;
        status[ST_CHB] = chb;
        status[ST_RATE_ERR] = rate_err;
        status[ST_BIST_OK] = ~strap_backcompat;
    end

    // sticky rate fault; a new fault beats the clear on read
    always_comb begin
        next_rate_err = rate_err;
        if (req.rd && req.addr == OFF_STATUS) begin
            next_rate_err = 1'b0;
        end
        if (cap_rate_err) begin
            next_rate_err = 1'b1;
        end
    end

    // pins, audio slotting and the forward frame
    always_comb begin
        // register driven outputs: enable bit and level bit of each nibble
        next_outs[8] = cfg.out78[7] & cfg.out78[4];
        next_outs[7] = cfg.out78[3] & cfg.out78[0];
        next_outs[6] = cfg.out56[7] & cfg.out56[4];
        next_outs[5] = cfg.out56[3] & cfg.out56[0];
        next_outs[4] = cfg.gpio3_out4[7] & cfg.gpio3_out4[4];
        next_gpio_oe = back_en;
        next_gpio_out = back_gpio & back_en;
        // audio goes in blanking unless active-video transport is set
        slot = cfg.general[GEN_ACTIVE] ? de_in : ~de_in;
        next_pend = pend;
        next_pend_valid = pend_valid;
        next_fwd = '0;
        next_fwd.rgb = rgb_in;
        if (mode18) begin
            // the freed low red and green bits carry no colour
            next_fwd.rgb[17:16] = 2'b00;
            next_fwd.rgb[9:8] = 2'b00;
        end
        next_fwd.de = de_in;
        next_fwd.mode18 = mode18;
        next_fwd.gpio = {rgb_in[9:8], rgb_in[17:16]} & fwd_en;
        next_fwd.audio_in_active = cfg.general[GEN_ACTIVE];
        if (pend_valid && slot) begin
            next_fwd.audio_valid = 1'b1;
            next_fwd.audio = pend;
            next_pend_valid = 1'b0;
        end
        // a fresh word replaces an unsent one; sources that never
        // leave a slot for a whole word lose samples
        if (cap_valid) begin
            next_pend = cap_word;
            next_pend_valid = 1'b1;
        end
    end

    // register everything that leaves the block
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_err <= 1'b0;
            pend <= '0;
            pend_valid <= 1'b0;
            fwd <= '0;
            gpio_out <= 4'h0;
            gpio_oe <= 4'h0;
            register_driven_outputs <= 5'h00;
            remote_mode18 <= 1'b0;
            bist_allowed <= 1'b0;
        end else begin
            rate_err <= next_rate_err;
            pend <= next_pend;
            pend_valid <= next_pend_valid;
            fwd <= next_fwd;
            gpio_out <= next_gpio_out;
            gpio_oe <= next_gpio_oe;
            register_driven_outputs <= next_outs;
            remote_mode18 <= mode18;
            bist_allowed <= ~strap_backcompat;
        end
    end

    // checks
    gpo_follow_a: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == OFF_OUT78 && req.wdata == 8'h90)
        |-> ##2 register_driven_outputs[8]) else $error("out8 not high");
    gpo_low_a: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == OFF_OUT56 && req.wdata == 8'h01)
        |-> ##2 !register_driven_outputs[5]) else $error("out5 not low");
    pin_idle_a: assert property (@(posedge clk) disable iff (rst)
        !$past(mode18) |-> (gpio_oe == 4'h0) && (fwd.gpio == 4'h0))
        else $error("pin active outside 18-bit");
    back_pin_a: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == OFF_GPIO3_OUT4 && req.wdata == 8'h05 && mode18)
        ##1 mode18 |-> ##1 gpio_oe[3]) else $error("pin 3 not driving");
    fwd_pin_a: assert property (@(posedge clk) disable iff (rst)
        $past(back_en[0]) && !$past(fwd_en[0]) |-> gpio_oe[0] && !fwd.gpio[0])
        else $error("pin 0 not driving alone");
    colour_cut_a: assert property (@(posedge clk) disable iff (rst)
        fwd.mode18 |-> (fwd.rgb[17:16] == 2'b00) && (fwd.rgb[9:8] == 2'b00))
        else $error("low colour bits leak in 18-bit");
    mode_write_a: assert property (@(posedge clk) disable iff (rst)
        (req.wr && req.addr == OFF_GENERAL && req.wdata == 8'h04)
        |-> ##2 remote_mode18 ##0 fwd.mode18) else $error("18-bit not entered");
    audio_slot_a: assert property (@(posedge clk) disable iff (rst)
        fwd.audio_valid |-> (fwd.audio_in_active ? fwd.de : !fwd.de))
        else $error("audio outside its slot");
    bist_gate_a: assert property (@(posedge clk) disable iff (rst)
        strap_backcompat ##1 strap_backcompat |-> !bist_allowed)
        else $error("self-test allowed in compatible mode");
    rate_flag_a: assert property (@(posedge clk) disable iff (rst)
        cap_rate_err |=> rate_err) else $error("rate fault lost");

endmodule : gpio_audio_core

/* File: dv/audio_link_model.sv */
`timescale 1ns/10ps
// audio source and far end of the serial link
module audio_link_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // scenario controls
    input wire logic fast,
    input wire logic [3:0] back_val,
    // link side
    input wire logic remote_mode18,
    output logic [3:0] back_gpio,
    // audio pins
    output logic bclk,
    output logic wclk,
    output logic data_a,
    output logic data_b
);
    logic [1:0] phase = 2'h0; // pixel clocks within one audio bit
    logic [3:0] bit_cnt = 4'h0; // bits within one word half
    // quarter rate normally; fast mode breaks the rate on purpose
    assign bclk = fast ? phase[0] : phase[1];
    // steady data keeps the sample known whatever the word edge
    assign data_a = 1'b1;
    assign data_b = 1'b1;
    // far end only sends pin values once it has followed into 18-bit mode
    assign back_gpio = remote_mode18 ? back_val : ~back_val;
    // word clock moves on a falling bit clock, aligned with both data lines
    always @(posedge clk) begin
        if (rst) begin
            phase <= 2'h0;
            bit_cnt <= 4'h0;
            wclk <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'hF) begin
                    wclk <= ~wclk;
                end
            end
        end
    end
endmodule : audio_link_model

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import gpio_audio_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0; // register access, idle
    logic strap_chb = 1'b0;
    logic strap_backcompat = 1'b0;
    logic [23:0] rgb_in = 24'h000000;
    logic de_in = 1'b0;
    logic de_hold = 1'b0; // keeps video active to test slot choice
    logic fast = 1'b0;
    logic [3:0] back_val = 4'h0;
    logic bclk, wclk, data_a, data_b, rvalid, remote_mode18, bist_allowed;
    logic [7:0] rdata;
    logic [3:0] gpio_out, gpio_oe, back_gpio;
    logic [8:4] register_driven_outputs;
    fwd_frame_t fwd;
    logic [7:0] exp_q[$]; // expected read answers, oldest first
    logic [7:0] gen = 8'h00; // general_config as last written
    logic audio_chk = 1'b0; // audio words judged only while set
    int words = 0;
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] gpo_d[4] = '{8'h90, 8'h10, 8'h09, 8'h01};
    logic [7:0] gp_a[4] = '{8'h0D, 8'h0E, 8'h0E, 8'h0F};
    logic [7:0] gp_f[4] = '{8'h93, 8'h03, 8'h30, 8'h03};
    logic [7:0] gp_b[4] = '{8'h95, 8'h05, 8'h50, 8'h05};
    logic [7:0] gen_v[4] = '{8'h00, 8'h01, 8'h00, 8'h02};
    logic strap_v[4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    always #50 clk = ~clk;

    gpio_audio_core uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .strap_chb(strap_chb), .strap_backcompat(strap_backcompat), .rgb_in(rgb_in),
        .de_in(de_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .i2s_bclk(bclk),
        .i2s_wclk(wclk), .i2s_data(data_a), .second_audio_data(data_b),
        .register_driven_outputs(register_driven_outputs), .back_gpio(back_gpio),
        .fwd(fwd), .remote_mode18(remote_mode18), .bist_allowed(bist_allowed));
    audio_link_model far (.clk(clk), .rst(rst), .fast(fast), .back_val(back_val),
        .remote_mode18(remote_mode18), .back_gpio(back_gpio), .bclk(bclk),
        .wclk(wclk), .data_a(data_a), .data_b(data_b));

    // random blanking unless held active
    always @(posedge clk) begin
        de_in <= de_hold | 1'($urandom_range(1));
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // one write; an idle edge follows so the strobe is never set twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : wr

    // one read; the answer is judged by the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_words(input int n);
        for (int k = 0; k < 1000 && words < n; k++) @(posedge clk);
        if (words < n) begin
            chk(words, n);
            end_sim();
        end
    endtask : wait_words

    // status byte worked out from straps and written config
    function automatic logic [7:0] stat(input logic rate);
        stat = {4'h0, ~strap_backcompat, rate, strap_chb | gen[0], strap_chb | gen[0] | gen[2]};
    endfunction : stat

    // monitor: read answers against notes, audio words against the source
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk(rvalid, 32'h0);
            else chk(rdata, exp_q.pop_front());
        end
        if (!audio_chk) begin
            words = 0;
        end else if (fwd.audio_valid === 1'b1) begin
            words++;
            if (words > 2) begin
                chk(fwd.audio.len, 32'h10);
                chk(fwd.audio.sample_a[15:0], 32'hFFFF);
                chk(fwd.audio.has_b, strap_chb | gen[0]);
                chk(fwd.audio.sample_b[15:0], (strap_chb | gen[0]) ? 32'hFFFF : 32'h0);
                chk(fwd.de, gen[1]);
                chk(fwd.audio_in_active, gen[1]);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h6c7d));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped and read-only places
        for (int a = 8'h0D; a <= 8'h12; a++) rd(8'(a), REG_RESET);
        rd(OFF_STATUS, stat(1'b0));
        wr(8'h20, 8'hFF);
        rd(8'h20, READ_NONE);
        wr(OFF_STATUS, 8'hFF);
        rd(OFF_STATUS, stat(1'b0));
        chk(register_driven_outputs, 32'h0);
        chk(bist_allowed, 32'h1);
        // register driven pins, every documented code, link toggling meanwhile
        for (int i = 0; i < 10; i++) begin
            wr(8'h11 - 8'(i / 4), gpo_d[i % 4]);
            back_val <= 4'($urandom());
            settle(3);
            chk(register_driven_outputs[8 - i / 2], !i[0]);
        end
        // general pins stay idle in 24-bit mode
        wr(OFF_GPIO3_OUT4, 8'h05);
        settle(3);
        chk(gpio_oe, 32'h0);
        chk(remote_mode18, 32'h0);
        wr(OFF_GPIO3_OUT4, 8'h00);
        gen = 8'h04;
        wr(OFF_GENERAL, gen);
        settle(3);
        chk(remote_mode18, 32'h1);
        chk(fwd.mode18, 32'h1);
        chk(gpio_oe, 32'h0);
        // each general pin forward then back
        for (int j = 0; j < 4; j++) begin
            for (int b = 0; b < 2; b++) begin
                wr(gp_a[j], b ? gp_b[j] : gp_f[j]);
                rgb_in <= 24'($urandom());
                back_val <= 4'($urandom());
                settle(4);
                if (b) begin
                    chk(gpio_oe[j], 32'h1);
                    chk(gpio_out[j], back_val[j]);
                end else begin
                    chk(gpio_oe[j], 32'h0);
                    chk(fwd.gpio[j], j < 2 ? rgb_in[16 + j] : rgb_in[6 + j]);
                    chk(fwd.rgb, rgb_in & 24'hFCFCFF);
                end
            end
        end
        wr(OFF_GPIO0, 8'h00);
        wr(OFF_GPIO12, 8'h00);
        wr(OFF_GPIO3_OUT4, 8'h00);
        // audio modes: plain, channel B by register, by strap, active video slot
        for (int k = 0; k < 4; k++) begin
            gen = gen_v[k];
            strap_chb <= strap_v[k];
            de_hold <= (k == 3);
            wr(OFF_GENERAL, gen);
            settle(3);
            chk(fwd.mode18, strap_chb | gen[0] | gen[2]);
            chk(fwd.rgb, (strap_chb | gen[0] | gen[2]) ? (rgb_in & 24'hFCFCFF) : rgb_in);
            rd(OFF_STATUS, stat(1'b0));
            audio_chk = 1'b1;
            wait_words(4);
            audio_chk = 1'b0;
        end
        // bit clock too fast is flagged, and the read clears it
        fast <= 1'b1;
        repeat (40) @(posedge clk);
        fast <= 1'b0;
        repeat (20) @(posedge clk);
        rd(OFF_STATUS, stat(1'b1));
        rd(OFF_STATUS, stat(1'b0));
        // no self test in backward compatible mode
        strap_backcompat <= 1'b1;
        settle(3);
        chk(bist_allowed, 32'h0);
        rd(OFF_STATUS, stat(1'b0));
        strap_backcompat <= 1'b0;
        settle(3);
        chk(bist_allowed, 32'h1);
        settle(3);
        end_sim();
    end
endmodule : tb_top
